// File: adc_pin_clock_and_result_control_tb.sv
// Self-checking bench for the converter pin, clock and result control block
`timescale 1ns/1ps
`default_nettype none
`include "apcr_cfg.svh"
module adc_pin_clock_and_result_control_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0, sar_raw, raw = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic pready, pslverr, err, alternate_clock = 0, internal_async_clock = 0, wait_mode = 0, stop3_mode = 0;
   logic [23:0] gpio_do = 24'hA5A5A5, gpio_drive = 24'h0F0F0F, gpio_pullup = 24'h3C3C3C, pad_di = 24'h5A5A5A;
   logic [23:0] pad_do, pad_oe_n, pad_pu_en, pad_ibuf_en, gpio_di;
   logic sar_done, conv_enable, conv_active, conv_start, converter_clock, async_clk_run, done_irq;
   int n_errors = 0, compares = 0, ac = 0, k, n;
   int per[4] = '{1, 2, 10, 12};
   apcr_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .alternate_clock, .internal_async_clock, .wait_mode, .stop3_mode, .sar_done, .sar_raw, .gpio_do,
      .gpio_drive, .gpio_pullup, .pad_di, .pad_do, .pad_oe_n, .pad_pu_en, .pad_ibuf_en, .gpio_di,
      .conv_enable, .conv_active, .conv_start, .converter_clock, .async_clk_run, .done_irq);
   apcr_sar_model #(.TICKS(4)) SAR (.pclk, .presetn, .conv_start, .conv_active, .converter_clock,
      .raw_in(raw), .sar_done, .sar_raw);
   always #2.5 pclk = ~pclk;
   // Slow sources kept well under half the bus rate so the synchroniser sees every edge
   always @(posedge pclk) begin
      ac <= ac + 1;
      if (ac % 5 == 4) alternate_clock <= ~alternate_clock;
      if (ac % 6 == 5) internal_async_clock <= ~internal_async_clock;
   end
   task automatic summarize;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic bad;
      n_errors++;
      $display("BAD %0t wait ran out", $time);
      summarize();
   endtask : bad
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ewait(ref logic s, input logic v, output int c);
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (s !== v && c < 3000);
      if (c >= 3000) bad();
   endtask : ewait
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      ewait(pready, 1'b1, n);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic pins(input logic [7:0] l, input logic [7:0] m, input logic [7:0] h);
      logic [23:0] p;
      p = {h, m, l};
      apb(1, `APCR_OFS_PD_LOW, l);
      apb(1, `APCR_OFS_PD_MID, m);
      apb(1, `APCR_OFS_PD_HIGH, h);
      @(posedge pclk);
      chk(pad_oe_n, {~gpio_drive | p});
      chk(pad_do, {gpio_do & ~p});
      chk(pad_pu_en, {gpio_pullup & ~p});
      chk(pad_ibuf_en, {~p});
      chk(gpio_di, {pad_di & ~p});
      apb(0, `APCR_OFS_PD_LOW, 0);
      chk(q, l);
      apb(0, `APCR_OFS_PD_MID, 0);
      chk(q, m);
      apb(0, `APCR_OFS_PD_HIGH, 0);
      chk(q, h);
   endtask : pins
   task automatic conv(input logic [7:0] cfg, input logic [7:0] ctl, input logic [11:0] r,
      input logic [7:0] eh, input logic [7:0] el, input logic ed);
      raw <= r;
      apb(1, `APCR_OFS_CFG, cfg);
      apb(1, `APCR_OFS_CTRL, ctl);
      ewait(conv_active, 1'b0, n);
      apb(0, `APCR_OFS_CTRL, 0);
      chk(q[8], ed);
      chk(done_irq, ed & ctl[7]);
      apb(0, `APCR_OFS_RES_HIGH, 0);
      chk(q, eh);
      apb(0, `APCR_OFS_RES_LOW, 0);
      chk(q, el);
   endtask : conv
   task automatic stopped;
      stop3_mode <= 1'b1;
      apb(1, `APCR_OFS_CFG, 32'h24);
      apb(1, `APCR_OFS_CTRL, 32'h4);
      k = 0;
      repeat (20) begin
         @(posedge pclk);
         if (converter_clock !== 1'b0) k++;
      end
      chk(k, 0);
      chk(conv_active, 1);
      // Compare write aborts the stalled conversion and leaves the result alone
      apb(1, `APCR_OFS_CMP, 32'h800);
      @(posedge pclk);
      chk(conv_active, 0);
      apb(0, `APCR_OFS_RES_HIGH, 0);
      chk(q, 32'h01);
      stop3_mode <= 1'b0;
   endtask : stopped
   initial begin
      repeat (10) @(posedge pclk);
      chk(conv_enable, 0);
      presetn <= 1'b1;
      apb(0, `APCR_OFS_CTRL, 0);
      chk(q, 32'h1F);
      apb(0, `APCR_OFS_CFG, 0);
      chk(q, 0);
      apb(0, 12'h020, 32'hFFFF);
      chk(err, 1);
      chk(q, 0);
      pins(8'h01, 8'h80, 8'h00);
      pins(8'hA5, 8'h00, 8'hFF);
      pins(8'h00, 8'hFF, 8'h81);
      pins(8'h00, 8'h00, 8'h00);
      conv(8'h04, 8'h83, 12'hABC, 8'h0A, 8'hBC, 1);
      conv(8'h08, 8'h05, 12'hABE, 8'h02, 8'hB0, 1);
      conv(8'h08, 8'h05, 12'hFFE, 8'h03, 8'hFF, 1);
      conv(8'h00, 8'h82, 12'hFFF, 8'h00, 8'hFF, 1);
      apb(1, `APCR_OFS_CMP, 32'h800);
      conv(8'h04, 8'h61, 12'h900, 8'h09, 8'h00, 1);
      conv(8'h04, 8'hE1, 12'h100, 8'h09, 8'h00, 0);
      conv(8'h04, 8'h41, 12'h100, 8'h01, 8'h00, 1);
      k = 0;
      repeat (30) begin
         @(posedge pclk);
         if (converter_clock !== 1'b0) k++;
      end
      chk(k, 0);
      chk(conv_enable, 1);
      for (int s = 0; s < 4; s++) begin
         for (int d = 0; d < 4; d++) begin
            stop3_mode <= (s == 3);
            wait_mode <= (s == 2);
            apb(1, `APCR_OFS_CFG, {d[1:0], 3'b001, s[1:0]});
            apb(1, `APCR_OFS_CTRL, 32'h4);
            ewait(converter_clock, 1'b1, n);
            ewait(converter_clock, 1'b1, k);
            chk(k, per[s] << d);
            chk(async_clk_run, s == 3);
            ewait(conv_active, 1'b0, n);
         end
      end
      stopped();
      apb(1, `APCR_OFS_CTRL, 32'h1F);
      repeat (3) @(posedge pclk);
      chk(conv_enable, 0);
      chk(conv_active, 0);
      summarize();
   end
endmodule : adc_pin_clock_and_result_control_tb
`default_nettype wire

// File: apcr_cfg.svh
// Offsets, field positions, reset values and codes of the converter control block
`ifndef APCR_CFG_SVH
`define APCR_CFG_SVH
`define APCR_OFS_PD_LOW 12'h000
`define APCR_OFS_PD_MID 12'h004
`define APCR_OFS_PD_HIGH 12'h008
`define APCR_OFS_CTRL 12'h00C
`define APCR_OFS_CFG 12'h010
`define APCR_OFS_RES_HIGH 12'h014
`define APCR_OFS_RES_LOW 12'h018
`define APCR_OFS_CMP 12'h01C
`define APCR_CTRL_CH_LSB 0
`define APCR_CTRL_CMPGT_BIT 5
`define APCR_CTRL_CMPEN_BIT 6
`define APCR_CTRL_IE_BIT 7
`define APCR_CTRL_DONE_BIT 8
`define APCR_CFG_CLK_LSB 0
`define APCR_CFG_MODE_LSB 2
`define APCR_CFG_DIV_LSB 5
`define APCR_CH_OFF 5'h1F
`define APCR_PD_RST 8'h00
`define APCR_MODE_8 2'h0
`define APCR_MODE_12 2'h1
`define APCR_MODE_10 2'h2
`define APCR_CLK_BUS 2'h0
`define APCR_CLK_HALF 2'h1
`define APCR_CLK_ALT 2'h2
`define APCR_CLK_ASYNC 2'h3
`define APCR_MAX10 10'h3FF
`define APCR_MAX8 8'hFF
`endif

// File: apcr_clkdiv.sv
// Divider that turns source ticks into converter clock ticks
`timescale 1ns/1ps
`default_nettype none
`include "apcr_cfg.svh"
module apcr_clkdiv (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic src_tick,
   input wire logic [1:0] div_sel,
   output logic tick
);
   apcr_pkg::apcr_div_s q_r;
   apcr_pkg::apcr_div_s q_nxt;
   logic [2:0] limit;

   always_comb begin
      limit = 3'h0;
      case (div_sel)
         2'h0: limit = 3'h0;
         2'h1: limit = 3'h1;
         2'h2: limit = 3'h3;
         default: limit = 3'h7;
      endcase
   end

   // Idle divider holds at zero to save power
   always_comb begin
      q_nxt = q_r;
      if (!run) begin
         q_nxt.cnt = 3'h0;
      end else if (src_tick) begin
         q_nxt.cnt = (q_r.cnt >= limit) ? 3'h0 : q_r.cnt + 3'h1;
      end
   end

   assign tick = run && src_tick && (q_r.cnt >= limit);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   AST_DIV_RATIO: assert property (@(posedge pclk) disable iff (!presetn)
      (run && src_tick && div_sel == 2'h1 && !tick) |=> ##[0:40] (tick || !run))
      else $error("Divide by two tick missing");
endmodule : apcr_clkdiv
`default_nettype wire

// File: apcr_pkg.sv
// Types shared by the converter control block
package apcr_pkg;
   typedef enum logic [1:0] {ST_DISABLED, ST_IDLE, ST_ACTIVE} apcr_state_e;
   typedef struct packed {
      logic [23:0] pd;
      logic [4:0] chsel;
      logic cmp_gt;
      logic cmp_en;
      logic ie;
      logic done;
      logic [1:0] div;
      logic [1:0] mode;
      logic [1:0] clksel;
      logic [11:0] cv;
      logic [7:0] res_h;
      logic [7:0] res_l;
      apcr_state_e st;
      logic half;
      logic start;
      logic [2:0] alt_sy;
      logic [2:0] ack_sy;
   } apcr_state_s;
   typedef struct packed {
      logic [2:0] cnt;
   } apcr_div_s;
endpackage : apcr_pkg

// File: apcr_sar_model.sv
// Analog core stand-in: answers a started conversion after a set number of converter ticks
`timescale 1ns/1ps
`default_nettype none
module apcr_sar_model #(
   parameter int TICKS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conv_start,
   input wire logic conv_active,
   input wire logic converter_clock,
   input wire logic [11:0] raw_in,
   output logic sar_done,
   output logic [11:0] sar_raw
);
   int n;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n <= 0;
         sar_done <= 1'b0;
         sar_raw <= 12'h5A5;
      end else begin
         sar_done <= 1'b0;
         // Raw bus toggles when not valid, so a stale value never passes
         sar_raw <= ~sar_raw;
         if (conv_start) begin
            n <= 0;
         end else if (conv_active && converter_clock) begin
            n <= n + 1;
            if (n == TICKS - 1) begin
               sar_done <= 1'b1;
               sar_raw <= raw_in;
            end
         end
      end
   end
endmodule : apcr_sar_model
`default_nettype wire

// File: apcr_top.sv
// Converter pin control, clock select, result placement and completion flag
//
// Overview of operation
// - Pin-disable bit 0 keeps port control of pin, 1 removes it.
// - Low pin-disable register bits 0..7 map to channels 0..7.
// - Middle pin-disable register bits 0..7 map to channels 8..15.
// - High pin-disable register bits 0..7 map to channels 16..23.
// - Disabled pin has its output driver forced to high impedance.
// - Disabled pin has input buffer off; port read returns zero.
// - Disabled pin has its pull-up forced off.
// - Converter disabled during reset and when channel select is all ones.
// - After completion converter idles in lowest power until next start.
// - 12-bit raw value; 10-bit mode rounds it to 10 bits.
// - 8-bit mode rounds 9-bit raw to 8 bits, low result only.
// - Store sets done flag; interrupt if enable set at that moment.
// - Compare enable checks each result against compare value, any mode.
// - Four clock sources, selected then divided, form converter clock.
// - Bus clock is the selected source after reset.
// - Halved bus clock with divider gives division up to 16.
// - Internal asynchronous clock keeps running in wait and stop3.
// - Divider ratios 1, 2, 4 or 8.
// - Mode 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
// - Source 00 bus, 01 bus halved, 10 alternate, 11 asynchronous.
// - Divide 00 by 1, 01 by 2, 10 by 4, 11 by 8.
// - Unused upper result bits read zero in 10 and 8-bit modes.
`timescale 1ns/1ps
`default_nettype none
`include "apcr_cfg.svh"
module apcr_top #(
   parameter int NCH = 24,
   parameter int RAW_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic alternate_clock,
   input wire logic internal_async_clock,
   input wire logic wait_mode,
   input wire logic stop3_mode,
   input wire logic sar_done,
   input wire logic [RAW_W-1:0] sar_raw,
   input wire logic [NCH-1:0] gpio_do,
   input wire logic [NCH-1:0] gpio_drive,
   input wire logic [NCH-1:0] gpio_pullup,
   input wire logic [NCH-1:0] pad_di,
   output logic [NCH-1:0] pad_do,
   output logic [NCH-1:0] pad_oe_n,
   output logic [NCH-1:0] pad_pu_en,
   output logic [NCH-1:0] pad_ibuf_en,
   output logic [NCH-1:0] gpio_di,
   output logic conv_enable,
   output logic conv_active,
   output logic conv_start,
   output logic converter_clock,
   output logic async_clk_run,
   output logic done_irq
);
   if (NCH != 24 || RAW_W != 12) begin : g_chk
      $error("apcr_top serves 24 channels and a 12-bit raw value only");
   end

   apcr_pkg::apcr_state_s s_r;
   apcr_pkg::apcr_state_s s_nxt;
   logic wr;
   logic rd;
   logic hit;
   logic src_tick;
   logic clk_run;
   logic store;
   logic cmp_ok;
   logic [11:0] rounded;
   logic [10:0] sum10;
   logic [8:0] sum8;
   logic [4:0] new_ch;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign new_ch = pwdata[`APCR_CTRL_CH_LSB +: 5];

   always_comb begin
      hit = 1'b1;
      prdata = 32'h0000_0000;
      case (paddr)
         `APCR_OFS_PD_LOW: prdata[7:0] = s_r.pd[7:0];
         `APCR_OFS_PD_MID: prdata[7:0] = s_r.pd[15:8];
         `APCR_OFS_PD_HIGH: prdata[7:0] = s_r.pd[23:16];
         `APCR_OFS_CTRL: begin
            prdata[`APCR_CTRL_CH_LSB +: 5] = s_r.chsel;
            prdata[`APCR_CTRL_CMPGT_BIT] = s_r.cmp_gt;
            prdata[`APCR_CTRL_CMPEN_BIT] = s_r.cmp_en;
            prdata[`APCR_CTRL_IE_BIT] = s_r.ie;
            prdata[`APCR_CTRL_DONE_BIT] = s_r.done;
         end
         `APCR_OFS_CFG: begin
            prdata[`APCR_CFG_CLK_LSB +: 2] = s_r.clksel;
            prdata[`APCR_CFG_MODE_LSB +: 2] = s_r.mode;
            prdata[`APCR_CFG_DIV_LSB +: 2] = s_r.div;
         end
         `APCR_OFS_RES_HIGH: prdata[7:0] = s_r.res_h;
         `APCR_OFS_RES_LOW: prdata[7:0] = s_r.res_l;
         `APCR_OFS_CMP: prdata[11:0] = s_r.cv;
         default: hit = 1'b0;
      endcase
   end

   // Unmapped access answers with an error and has no effect
   assign pslverr = psel && penable && !hit;

   // Pin forcing stays combinational so a set bit acts at once
   assign pad_do = gpio_do & ~s_r.pd;
   assign pad_oe_n = ~(gpio_drive & ~s_r.pd);
   assign pad_ibuf_en = ~s_r.pd;
   assign gpio_di = pad_di & ~s_r.pd;
   assign pad_pu_en = gpio_pullup & ~s_r.pd;

   // Source selection; outside pins are synchronised, edges taken after stage two
   always_comb begin
      src_tick = 1'b0;
      case (s_r.clksel)
         `APCR_CLK_BUS: src_tick = 1'b1;
         `APCR_CLK_HALF: src_tick = s_r.half;
         `APCR_CLK_ALT: src_tick = s_r.alt_sy[1] && !s_r.alt_sy[2];
         default: src_tick = s_r.ack_sy[1] && !s_r.ack_sy[2];
      endcase
   end

   // Only the asynchronous source survives stop3; wait keeps bus sources alive
   assign clk_run = (s_r.st == apcr_pkg::ST_ACTIVE)
      && (!stop3_mode || s_r.clksel == `APCR_CLK_ASYNC);
   assign async_clk_run = (s_r.st == apcr_pkg::ST_ACTIVE)
      && (s_r.clksel == `APCR_CLK_ASYNC);

   apcr_clkdiv u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(clk_run),
      .src_tick(src_tick),
      .div_sel(s_r.div),
      .tick(converter_clock)
   );

   // Rounding saturates so a full-scale raw value never wraps to zero
   assign sum10 = {1'b0, sar_raw[11:2]} + {10'h000, sar_raw[1]};
   assign sum8 = {1'b0, sar_raw[8:1]} + {8'h00, sar_raw[0]};

   always_comb begin
      rounded = sar_raw;
      case (s_r.mode)
         `APCR_MODE_10: rounded = {2'h0, sum10[10] ? `APCR_MAX10 : sum10[9:0]};
         `APCR_MODE_8: rounded = {4'h0, sum8[8] ? `APCR_MAX8 : sum8[7:0]};
         default: rounded = sar_raw;
      endcase
   end

   assign cmp_ok = !s_r.cmp_en
      || (s_r.cmp_gt ? (rounded >= s_r.cv) : (rounded < s_r.cv));
   assign store = sar_done && (s_r.st == apcr_pkg::ST_ACTIVE) && cmp_ok;

   always_comb begin
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      s_nxt.half = !s_r.half;
      s_nxt.alt_sy = {s_r.alt_sy[1:0], alternate_clock};
      s_nxt.ack_sy = {s_r.ack_sy[1:0], internal_async_clock};
      if (rd && paddr == `APCR_OFS_RES_LOW) begin
         s_nxt.done = 1'b0;
      end
      if (sar_done && s_r.st == apcr_pkg::ST_ACTIVE) begin
         s_nxt.st = apcr_pkg::ST_IDLE;
      end
      if (wr) begin
         case (paddr)
            `APCR_OFS_PD_LOW: s_nxt.pd[7:0] = pwdata[7:0];
            `APCR_OFS_PD_MID: s_nxt.pd[15:8] = pwdata[7:0];
            `APCR_OFS_PD_HIGH: s_nxt.pd[23:16] = pwdata[7:0];
            `APCR_OFS_CTRL: begin
               s_nxt.chsel = new_ch;
               s_nxt.cmp_gt = pwdata[`APCR_CTRL_CMPGT_BIT];
               s_nxt.cmp_en = pwdata[`APCR_CTRL_CMPEN_BIT];
               s_nxt.ie = pwdata[`APCR_CTRL_IE_BIT];
               s_nxt.done = 1'b0;
               // Writing all ones parks the converter, any other channel starts it
               if (new_ch == `APCR_CH_OFF) begin
                  s_nxt.st = apcr_pkg::ST_DISABLED;
               end else begin
                  s_nxt.st = apcr_pkg::ST_ACTIVE;
                  s_nxt.start = 1'b1;
               end
            end
            `APCR_OFS_CFG: begin
               s_nxt.clksel = pwdata[`APCR_CFG_CLK_LSB +: 2];
               s_nxt.mode = pwdata[`APCR_CFG_MODE_LSB +: 2];
               s_nxt.div = pwdata[`APCR_CFG_DIV_LSB +: 2];
            end
            `APCR_OFS_CMP: s_nxt.cv = pwdata[11:0];
            default: s_nxt.cv = s_r.cv;
         endcase
         // Config or compare change makes a running conversion meaningless
         if ((paddr == `APCR_OFS_CFG || paddr == `APCR_OFS_CMP)
               && s_r.st == apcr_pkg::ST_ACTIVE) begin
            s_nxt.st = apcr_pkg::ST_IDLE;
         end
      end
      if (store) begin
         s_nxt.res_h = {4'h0, rounded[11:8]};
         s_nxt.res_l = rounded[7:0];
         s_nxt.done = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.pd <= {3{`APCR_PD_RST}};
         s_r.chsel <= `APCR_CH_OFF;
         s_r.clksel <= `APCR_CLK_BUS;
         s_r.mode <= `APCR_MODE_8;
         s_r.st <= apcr_pkg::ST_DISABLED;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign conv_enable = (s_r.st != apcr_pkg::ST_DISABLED);
   assign conv_active = (s_r.st == apcr_pkg::ST_ACTIVE);
   assign conv_start = s_r.start;
   assign done_irq = s_r.done && s_r.ie;

   sequence seq_finish;
      sar_done && conv_active;
   endsequence

   sequence seq_store;
      store && !wr;
   endsequence

   // Start pulse lasts exactly one cycle
   sequence seq_launch;
      conv_start && conv_active && conv_enable ##1 !conv_start;
   endsequence

   AST_PIN_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
      ((pad_oe_n & s_r.pd) == s_r.pd))
      else $error("Disabled pin still driven");
   AST_PIN_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      ((gpio_di & s_r.pd) == '0 && (pad_ibuf_en & s_r.pd) == '0))
      else $error("Disabled pin input visible");
   AST_PIN_PULLUP: assert property (@(posedge pclk) disable iff (!presetn)
      ((pad_pu_en & s_r.pd) == '0))
      else $error("Disabled pin pull-up on");
   AST_CH_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `APCR_OFS_CTRL && new_ch == `APCR_CH_OFF) |=> !conv_enable && !conv_active)
      else $error("Converter enabled with all-ones channel");
   AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      seq_finish and !wr |=> !conv_active && !converter_clock && !async_clk_run)
      else $error("Converter not idle after completion");
   AST_ROUND10: assert property (@(posedge pclk) disable iff (!presetn)
      (store && s_r.mode == `APCR_MODE_10) |=> s_r.res_h[7:2] == 6'h00)
      else $error("10-bit result upper bits set");
   AST_ROUND8: assert property (@(posedge pclk) disable iff (!presetn)
      (store && s_r.mode == `APCR_MODE_8) |=> s_r.res_h == 8'h00 && s_r.res_l == $past(rounded[7:0]))
      else $error("8-bit result placement wrong");
   AST_DONE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      seq_store |=> s_r.done && (done_irq == $past(s_r.ie)))
      else $error("Completion flag or interrupt wrong");
   AST_CMP_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
      (sar_done && conv_active && s_r.cmp_en && !cmp_ok && !s_r.done && !wr) |=> !s_r.done)
      else $error("Result stored although compare failed");
   AST_BUS_SRC: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_run && s_r.clksel == `APCR_CLK_BUS && s_r.div == 2'h0) |-> converter_clock)
      else $error("Bus clock divide by one not every cycle");
   AST_ASYNC_STOP: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_active && stop3_mode && s_r.clksel == `APCR_CLK_ASYNC) |-> async_clk_run && clk_run)
      else $error("Asynchronous clock stopped in stop3");
   AST_STOP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      (stop3_mode && s_r.clksel != `APCR_CLK_ASYNC) |-> !converter_clock)
      else $error("Converter clock ticked in stop3 from a stopped source");
   AST_WAIT_RUN: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_active && wait_mode && !stop3_mode) |-> clk_run)
      else $error("Converter clock stopped in wait");

   // Divider spacing: ticks never closer than the selected ratio
   AST_HALF_SRC: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_run && s_r.clksel == `APCR_CLK_HALF && s_r.div == 2'h0 && converter_clock) |=> !converter_clock)
      else $error("Halved bus source ticked twice in a row");
   AST_DIV4: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_run && s_r.clksel == `APCR_CLK_BUS && s_r.div == 2'h2 && converter_clock) |=> (!converter_clock) [*3])
      else $error("Divide by four tick too early");
   AST_DIV8: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_run && s_r.clksel == `APCR_CLK_BUS && s_r.div == 2'h3 && converter_clock) |=> (!converter_clock) [*7])
      else $error("Divide by eight tick too early");
   AST_NO_TICK_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      !conv_active |-> !converter_clock && !async_clk_run)
      else $error("Clock running while idle");

   // Register to pin mapping, one byte per register
   AST_PIN_PASS: assert property (@(posedge pclk) disable iff (!presetn)
      ((pad_do | s_r.pd) == (gpio_do | s_r.pd)) && ((pad_oe_n & ~s_r.pd) == (~gpio_drive & ~s_r.pd)))
      else $error("Enabled pin does not follow port logic");
   AST_PIN_LOW_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `APCR_OFS_PD_LOW) |=> pad_ibuf_en[7:0] == ~$past(pwdata[7:0]))
      else $error("Low pin-disable byte maps wrong");
   AST_PIN_MID_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `APCR_OFS_PD_MID) |=> pad_ibuf_en[15:8] == ~$past(pwdata[7:0]))
      else $error("Middle pin-disable byte maps wrong");
   AST_PIN_HIGH_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `APCR_OFS_PD_HIGH) |=> pad_ibuf_en[23:16] == ~$past(pwdata[7:0]))
      else $error("High pin-disable byte maps wrong");

   // Result placement per mode
   AST_MODE12: assert property (@(posedge pclk) disable iff (!presetn)
      (store && s_r.mode == `APCR_MODE_12) |=> {s_r.res_h, s_r.res_l} == {4'h0, $past(sar_raw)})
      else $error("12-bit result placement wrong");
   AST_ROUND10_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
      (store && s_r.mode == `APCR_MODE_10 && sar_raw[11:1] != 11'h7FF)
      |=> {s_r.res_h[1:0], s_r.res_l} == $past(sar_raw[11:2]) + {9'h000, $past(sar_raw[1])})
      else $error("10-bit rounding wrong");
   AST_SAT10: assert property (@(posedge pclk) disable iff (!presetn)
      (store && s_r.mode == `APCR_MODE_10 && sar_raw[11:1] == 11'h7FF)
      |=> {s_r.res_h[1:0], s_r.res_l} == `APCR_MAX10)
      else $error("10-bit full scale wrapped");
   AST_SAT8: assert property (@(posedge pclk) disable iff (!presetn)
      (store && s_r.mode == `APCR_MODE_8 && sar_raw[8:0] == 9'h1FF) |=> s_r.res_l == `APCR_MAX8)
      else $error("8-bit full scale wrapped");

   // Launch, abort and reset behaviour
   AST_START: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `APCR_OFS_CTRL && new_ch != `APCR_CH_OFF) |=> seq_launch)
      else $error("Conversion did not start");
   AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && (paddr == `APCR_OFS_CFG || paddr == `APCR_OFS_CMP) && conv_active && !sar_done)
      |=> !conv_active && $stable(s_r.res_h) && $stable(s_r.res_l))
      else $error("Aborted conversion changed the result");
   AST_DONE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && paddr == `APCR_OFS_RES_LOW && !store) |=> !s_r.done)
      else $error("Done flag not cleared by result read");
   AST_RESET_SRC: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> s_r.clksel == `APCR_CLK_BUS && !conv_enable)
      else $error("Reset left wrong clock source or enabled converter");
   AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pslverr) |-> prdata == 32'h0000_0000)
      else $error("Unmapped read returned data");
endmodule : apcr_top
`default_nettype wire
